// ==== core_model.sv ====
// Behavioural model of the core's sleep and interrupt lines.
`timescale 1ns/1ps
module core_model (
  input  wire logic clk_i,       // System clock.
  input  wire logic sleep_cmd_i, // Bench asks for a sleep.
  input  wire logic irq_cmd_i,   // Bench raises an interrupt.
  output logic      sleep_req_o, // One-cycle sleep request.
  output logic      irq_o        // Interrupt pending level.
);
  // core request lines
  // Registered, so the lines move just after an edge like a real core.
  always_ff @(posedge clk_i) begin
    sleep_req_o <= sleep_cmd_i;
    irq_o       <= irq_cmd_i;
  end
endmodule : core_model

// ==== pmrc_pkg.sv ====
// Constants, types and carriers of the power-mode and reset controller.
package pmrc_pkg;

  // ****************************************************************
  // Register map, byte offsets on the bus.
  // ****************************************************************
  localparam logic [4:0] REG_MODE   = 5'h00; // Mode and clock select.
  localparam logic [4:0] REG_BOD    = 5'h04; // Brown-out levels.
  localparam logic [4:0] REG_STAT   = 5'h08; // Read-only status.
  localparam logic [4:0] REG_SEN_LO = 5'h0c; // Start enables 31..0.
  localparam logic [4:0] REG_SEN_HI = 5'h10; // Start enables 39..32.
  localparam logic [4:0] REG_SPD_LO = 5'h14; // Start pending 31..0.
  localparam logic [4:0] REG_SPD_HI = 5'h18; // Start pending 39..32.
  localparam logic [4:0] REG_CAUSE  = 5'h1c; // Sticky reset cause.

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int MODE_SEL_LSB = 0;  // Requested low-power mode.
  localparam int MODE_KWDO    = 2;  // Keep watchdog oscillator.
  localparam int MODE_KBOD    = 3;  // Keep brown-out detector.
  localparam int MODE_CLK_LSB = 4;  // Main clock source select.
  localparam int BOD_IRQ_LSB  = 0;  // Interrupt level select.
  localparam int BOD_RST_LSB  = 2;  // Forced reset level select.
  localparam int BOD_RSTEN    = 4;  // Forced reset enable.
  localparam int STAT_BOD     = 0;  // Live brown-out interrupt.
  localparam int STAT_ISP     = 1;  // Boot request seen at reset.
  localparam int CAUSE_POR    = 0;  // Power-on reset.
  localparam int CAUSE_PIN    = 1;  // External reset pin.
  localparam int CAUSE_WDT    = 2;  // Watchdog reset.
  localparam int CAUSE_BOD    = 3;  // Brown-out forced reset.
  localparam int CAUSE_WAKE   = 4;  // Wake from power-down.

  // ****************************************************************
  // Encodings, counts and timing.
  // ****************************************************************
  localparam int          START_N  = 40;     // Start logic pins.
  localparam int          HI_N     = 8;      // Pins in high word.
  localparam int          RCNT_W   = 8;      // Reset hold counter.
  localparam logic [1:0]  LP_SLEEP = 2'h0;   // Light sleep.
  localparam logic [1:0]  LP_DEEP  = 2'h1;   // Deep sleep.
  localparam logic [1:0]  LP_PDOWN = 2'h2;   // Full power-down.
  localparam logic [1:0]  CLK_IRC  = 2'h0;   // Internal RC source.
  localparam logic [31:0] BOOT_FETCH_ADDR = 32'h0; // First fetch.
  localparam int CLK_PERIOD_NS = 25;         // 40 MHz clock.
  localparam int WAKE_PULSE_NS = 50;         // Shortest wake pulse.
  // Least pulse in whole cycles, rounded up.
  localparam int WAKE_MIN_CYC =
    (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Samples such a pulse is sure to give, never less than one.
  localparam logic [1:0] WAKE_SAMPLES =
    2'((WAKE_MIN_CYC > 1) ? WAKE_MIN_CYC - 1 : 1);

  // Controller states.
  typedef enum logic [2:0] {
    ST_RESET, ST_RUN, ST_SLEEP, ST_DEEP, ST_PDOWN
  } pm_state_t;

  // Raw pins and analogue comparator flags, all asynchronous.
  typedef struct packed {
    logic [START_N-1:0] start;   // Start logic pins.
    logic               wake_n;  // Power-down wake pin.
    logic               rst_n;   // External reset pin.
    logic               boot_n;  // Boot request pin.
    logic               por;     // Power-on reset flag.
    logic [3:0]         bod_irq; // Supply below interrupt level n.
    logic [3:0]         bod_rst; // Supply below reset level n.
  } pins_t;

  // Power and clock enables to the rest of the chip.
  typedef struct packed {
    logic core_clk; // Processor core clock.
    logic per_clk;  // Peripheral clocks.
    logic analog;   // System oscillator and PLLs.
    logic internal_rc_osc;      // Internal RC oscillator.
    logic wdosc;    // Watchdog oscillator.
    logic brownout_detector;      // Brown-out detector.
    logic power;    // Main supply switch.
  } pwr_t;

  // Complete state of the controller.
  typedef struct packed {
    pm_state_t          st;       // Controller state.
    logic               ack;      // Bus acknowledge.
    logic [31:0]        rdata;    // Bus read data.
    logic [1:0]         mode;     // Requested low-power mode.
    logic               kwdo;     // Keep watchdog osc in deep.
    logic               kbod;     // Keep brown-out in deep.
    logic [1:0]         clk_sel;  // Main clock source.
    logic [1:0]         bod_ilvl; // Interrupt level.
    logic [1:0]         bod_rlvl; // Forced reset level.
    logic               bod_ren;  // Forced reset enable.
    logic [START_N-1:0] sen;      // Start enables.
    logic [START_N-1:0] spd;      // Start pending flags.
    logic [START_N-1:0] sprev;    // Last synchronised pins.
    logic [START_N-1:0] sirq;     // Per-pin interrupt lines.
    logic [4:0]         cause;    // Reset cause flags.
    logic [RCNT_W-1:0]  rcnt;     // Reset hold counter.
    logic [1:0]         wcnt;     // Wake pin low samples.
    logic               boot_isp; // Programming handler request.
    logic               finit;    // Flash initialise pulse.
    logic               sys_rst;  // Chip-wide reset.
    logic               bod_irq;  // Brown-out interrupt.
    logic [31:0]        fetch;    // First fetch address.
    pins_t              s1;       // First synchroniser stage.
    pins_t              s2;       // Second synchroniser stage.
    pwr_t               pwr;      // Power and clock enables.
  } st_t;

endpackage : pmrc_pkg

// ==== power_mode_reset_control.sv ====
// Power-mode, wake-up and reset controller with a Wishbone slave.
`timescale 1ns/1ps
module power_mode_reset_control #(
  parameter logic [7:0] RST_HOLD_CYC = 8'h10 // Reset stretch cycles.
) (
  input  wire logic                 clk_i,       // Always-on clock.
  input  wire logic                 rst_i,       // Sync reset, high.
  input  wire logic                 wb_cyc_i,    // Bus cycle.
  input  wire logic                 wb_stb_i,    // Bus strobe.
  input  wire logic                 wb_we_i,     // Write enable.
  input  wire logic [4:0]           wb_adr_i,    // Byte address.
  input  wire logic [3:0]           wb_sel_i,    // Byte enables.
  input  wire logic [31:0]          wb_dat_i,    // Write data.
  output logic      [31:0]          wb_dat_o,    // Read data.
  output logic                      wb_ack_o,    // Acknowledge.
  input  wire pmrc_pkg::pins_t      pins_i,      // Raw pins.
  input  wire logic                 wdt_rst_i,   // Watchdog reset.
  input  wire logic                 sleep_req_i, // Core sleep pulse.
  input  wire logic                 irq_i,       // Core irq pending.
  output pmrc_pkg::pwr_t            pwr_o,       // Power enables.
  output logic [1:0]                clk_sel_o,   // Main clock select.
  output logic                      sys_rst_o,   // Chip reset.
  output logic                      flash_init_o, // Flash init pulse.
  output logic [31:0]               fetch_addr_o, // First fetch.
  output logic                      boot_isp_o,  // Programming request.
  output logic                      bod_irq_o,   // Brown-out interrupt.
  output logic [pmrc_pkg::START_N-1:0] start_irq_o // Start lines.
);

  // ****************************************************************
  // Functions.
  // ****************************************************************

  // Byte-lane merge of a write into an old register value.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Write-one-to-clear mask, lanes gated by the byte enables.
  function automatic logic [31:0] w1c(input logic [31:0] wd,
                                      input logic [3:0]  sel);
    return merge(32'h0, wd, sel);
  endfunction : w1c

  // ****************************************************************
  // State registers.
  // ****************************************************************
  pmrc_pkg::st_t      q;        // Present state.
  pmrc_pkg::st_t      n;        // Next state.
  logic [pmrc_pkg::START_N-1:0] s_edge; // Rising start pin events.
  logic               src_rst;  // Any of the four reset sources.
  logic               bod_force; // Brown-out forced reset.
  logic               wr;       // Bus write this cycle.
  logic               rd;       // Bus read this cycle.
  logic [31:0]        wv;       // Merged write value.
  logic [31:0]        clr;      // Write-one-to-clear mask.

  // Reset state; the chip reset sequence runs from here.
  function automatic pmrc_pkg::st_t rst_state();
    pmrc_pkg::st_t r;
    r = '0;
    r.st        = pmrc_pkg::ST_RESET;
    r.rcnt      = RST_HOLD_CYC;
    r.sys_rst   = 1'b1;
    r.pwr.internal_rc_osc   = 1'b1;
    r.pwr.power = 1'b1;
    r.pwr.wdosc = 1'b1;
    r.pwr.brownout_detector   = 1'b1;
    r.s1.wake_n = 1'b1;
    r.s2.wake_n = 1'b1;
    r.s1.rst_n  = 1'b1;
    r.s2.rst_n  = 1'b1;
    r.s1.boot_n = 1'b1;
    r.s2.boot_n = 1'b1;
    r.clk_sel   = pmrc_pkg::CLK_IRC;
    r.fetch     = pmrc_pkg::BOOT_FETCH_ADDR;
    return r;
  endfunction : rst_state

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************

  // All behaviour is computed here into the next copy of the state.
  // The controller clock is the always-on one, so start pins are seen
  // even while every clock it gates off is stopped.
  always_comb begin
    n      = q;
    n.s1   = pins_i;
    n.s2   = q.s1;
    n.ack  = 1'b0;
    n.finit = 1'b0;
    wr     = wb_cyc_i && wb_stb_i && !q.ack && wb_we_i;
    rd     = wb_cyc_i && wb_stb_i && !q.ack && !wb_we_i;
    wv     = 32'h0;
    clr    = wr ? w1c(wb_dat_i, wb_sel_i) : 32'h0;
    bod_force = q.bod_ren && q.pwr.brownout_detector && q.s2.bod_rst[q.bod_rlvl];
    src_rst = !q.s2.rst_n || wdt_rst_i || q.s2.por || bod_force;
    s_edge  = q.s2.start & ~q.sprev;
    n.sprev = q.s2.start;

    // Bus slave: one-cycle answer, unmapped reads give zero.
    n.ack = wb_cyc_i && wb_stb_i && !q.ack;
    if (rd) begin
      case (wb_adr_i)
        pmrc_pkg::REG_MODE: begin
          n.rdata = 32'h0;
          n.rdata[pmrc_pkg::MODE_SEL_LSB +: 2] = q.mode;
          n.rdata[pmrc_pkg::MODE_KWDO] = q.kwdo;
          n.rdata[pmrc_pkg::MODE_KBOD] = q.kbod;
          n.rdata[pmrc_pkg::MODE_CLK_LSB +: 2] = q.clk_sel;
        end
        pmrc_pkg::REG_BOD: begin
          n.rdata = 32'h0;
          n.rdata[pmrc_pkg::BOD_IRQ_LSB +: 2] = q.bod_ilvl;
          n.rdata[pmrc_pkg::BOD_RST_LSB +: 2] = q.bod_rlvl;
          n.rdata[pmrc_pkg::BOD_RSTEN] = q.bod_ren;
        end
        pmrc_pkg::REG_STAT: begin
          n.rdata = 32'h0;
          n.rdata[pmrc_pkg::STAT_BOD] = q.bod_irq;
          n.rdata[pmrc_pkg::STAT_ISP] = q.boot_isp;
        end
        pmrc_pkg::REG_SEN_LO: n.rdata = q.sen[31:0];
        pmrc_pkg::REG_SEN_HI: n.rdata = {24'h0, q.sen[39:32]};
        pmrc_pkg::REG_SPD_LO: n.rdata = q.spd[31:0];
        pmrc_pkg::REG_SPD_HI: n.rdata = {24'h0, q.spd[39:32]};
        pmrc_pkg::REG_CAUSE:  n.rdata = {27'h0, q.cause};
        default:              n.rdata = 32'h0;
      endcase
    end

    // Register writes; pending and cause bits are write-one-clear.
    if (wr) begin
      case (wb_adr_i)
        pmrc_pkg::REG_MODE: begin
          wv = merge({26'h0, q.clk_sel, q.kbod, q.kwdo, q.mode},
                     wb_dat_i, wb_sel_i);
          n.mode    = wv[pmrc_pkg::MODE_SEL_LSB +: 2];
          n.kwdo    = wv[pmrc_pkg::MODE_KWDO];
          n.kbod    = wv[pmrc_pkg::MODE_KBOD];
          n.clk_sel = wv[pmrc_pkg::MODE_CLK_LSB +: 2];
        end
        pmrc_pkg::REG_BOD: begin
          wv = merge({27'h0, q.bod_ren, q.bod_rlvl, q.bod_ilvl},
                     wb_dat_i, wb_sel_i);
          n.bod_ilvl = wv[pmrc_pkg::BOD_IRQ_LSB +: 2];
          n.bod_rlvl = wv[pmrc_pkg::BOD_RST_LSB +: 2];
          n.bod_ren  = wv[pmrc_pkg::BOD_RSTEN];
        end
        pmrc_pkg::REG_SEN_LO:
          n.sen[31:0] = merge(q.sen[31:0], wb_dat_i, wb_sel_i);
        pmrc_pkg::REG_SEN_HI: begin
          wv = merge({24'h0, q.sen[39:32]}, wb_dat_i, wb_sel_i);
          n.sen[39:32] = wv[pmrc_pkg::HI_N-1:0];
        end
        default: begin
        end
      endcase
    end

    // Start pending flags; a new event wins over a clear.
    // start pins as interrupts
    n.spd = q.spd & ~((wb_adr_i == pmrc_pkg::REG_SPD_LO)
              ? {8'h0, clr} : {clr[7:0], 32'h0}) | (s_edge & q.sen);
    if (!(wr && (wb_adr_i == pmrc_pkg::REG_SPD_LO ||
                 wb_adr_i == pmrc_pkg::REG_SPD_HI))) begin
      n.spd = q.spd | (s_edge & q.sen);
    end
    n.sirq = n.spd & q.sen;

    n.bod_irq = q.pwr.brownout_detector && q.s2.bod_irq[q.bod_ilvl];

    // Reset cause flags, set wins over a clear.
    if (wr && wb_adr_i == pmrc_pkg::REG_CAUSE) begin
      n.cause = q.cause & ~clr[4:0];
    end

    case (q.st)
      // Stretch the chip reset, then release the core.
      pmrc_pkg::ST_RESET: begin
        if (q.rcnt != '0) begin
          n.rcnt = q.rcnt - 1'b1;
        end
        n.finit = (q.rcnt == RST_HOLD_CYC - 8'h01);
        if (q.rcnt == '0) begin
          n.boot_isp = !q.s2.boot_n;
          n.st       = pmrc_pkg::ST_RUN;
          n.sys_rst  = 1'b0;
          n.pwr      = '1;
        end
      end
      // Running: a sleep request applies the recorded mode.
      pmrc_pkg::ST_RUN: begin
        if (sleep_req_i) begin
          n.pwr.core_clk = 1'b0;
          case (q.mode)
            pmrc_pkg::LP_SLEEP: n.st = pmrc_pkg::ST_SLEEP;
            pmrc_pkg::LP_DEEP: begin
              n.st          = pmrc_pkg::ST_DEEP;
              n.pwr.per_clk = 1'b0;
              n.pwr.analog  = 1'b0;
              n.pwr.internal_rc_osc     = 1'b0;
              n.pwr.wdosc   = q.kwdo;
              n.pwr.brownout_detector     = q.kbod;
            end
            pmrc_pkg::LP_PDOWN: begin
              n.st   = pmrc_pkg::ST_PDOWN;
              n.pwr  = '0;
              n.wcnt = '0;
            end
            default: n.pwr.core_clk = 1'b1;
          endcase
        end
      end
      // Light sleep: peripherals run, an interrupt resumes the core.
      pmrc_pkg::ST_SLEEP: begin
        if (irq_i) begin
          n.st           = pmrc_pkg::ST_RUN;
          n.pwr.core_clk = 1'b1;
        end
      end
      // Deep sleep: enabled start pin events or interrupts wake.
      pmrc_pkg::ST_DEEP: begin
        if (|(s_edge & q.sen) || irq_i) begin
          n.st  = pmrc_pkg::ST_RUN;
          n.pwr = '1;
        end
      end
      // Power-down: only a low sample run on the wake pin leaves.
      pmrc_pkg::ST_PDOWN: begin
        n.wcnt = q.s2.wake_n ? 2'h0 : q.wcnt + 2'h1;
        if (!q.s2.wake_n && q.wcnt + 2'h1 >= pmrc_pkg::WAKE_SAMPLES)
        begin
          n = rst_state();
          n.cause = q.cause;
          n.cause[pmrc_pkg::CAUSE_WAKE] = 1'b1;
        end
      end
      default: n.st = pmrc_pkg::ST_RESET;
    endcase

    // Any source outside power-down restarts the chip.
    if (src_rst && q.st != pmrc_pkg::ST_PDOWN) begin
      n = rst_state();
      n.s1    = pins_i;
      n.s2    = q.s1;
      n.ack   = wb_cyc_i && wb_stb_i && !q.ack;
      n.cause = q.cause;
      n.cause[pmrc_pkg::CAUSE_PIN] = q.cause[pmrc_pkg::CAUSE_PIN]
                                   | !q.s2.rst_n;
      n.cause[pmrc_pkg::CAUSE_WDT] = q.cause[pmrc_pkg::CAUSE_WDT]
                                   | wdt_rst_i;
      n.cause[pmrc_pkg::CAUSE_POR] = q.cause[pmrc_pkg::CAUSE_POR]
                                   | q.s2.por;
      n.cause[pmrc_pkg::CAUSE_BOD] = q.cause[pmrc_pkg::CAUSE_BOD]
                                   | bod_force;
    end
  end

  // Register the whole state; the bus reset restarts the sequence.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= rst_state();
    end else begin
      q <= n;
    end
  end

  // ****************************************************************
  // Outputs, each straight from a state flip-flop.
  // ****************************************************************
  assign wb_dat_o     = q.rdata;
  assign wb_ack_o     = q.ack;
  assign pwr_o        = q.pwr;
  assign clk_sel_o    = q.clk_sel;
  assign sys_rst_o    = q.sys_rst;
  assign flash_init_o = q.finit;
  assign fetch_addr_o = q.fetch;
  assign boot_isp_o   = q.boot_isp;
  assign bod_irq_o    = q.bod_irq;
  assign start_irq_o  = q.sirq;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_CORE_GATE: assert property (
    q.st == pmrc_pkg::ST_SLEEP |-> !q.pwr.core_clk)
    else $error("Core clock runs in light sleep.");
  AST_SLEEP_WAKE: assert property (
    q.st == pmrc_pkg::ST_SLEEP && irq_i && !src_rst
    |=> q.st == pmrc_pkg::ST_RUN && q.pwr.core_clk)
    else $error("Interrupt did not resume the core.");
  AST_PERIPH_ON: assert property (
    q.st == pmrc_pkg::ST_SLEEP |-> q.pwr.per_clk && q.pwr.analog)
    else $error("Peripheral clock stopped in light sleep.");
  AST_DEEP_OFF: assert property (
    q.st == pmrc_pkg::ST_DEEP |-> !q.pwr.analog && !q.pwr.core_clk)
    else $error("Analogue blocks left on in deep sleep.");
  AST_DEEP_KEEP: assert property (
    q.st == pmrc_pkg::ST_RUN && sleep_req_i && !src_rst
    && q.mode == pmrc_pkg::LP_DEEP
    |=> q.pwr.wdosc == $past(q.kwdo) && q.pwr.brownout_detector == $past(q.kbod))
    else $error("Deep sleep keep options not applied.");
  AST_PDOWN_HOLD: assert property (
    q.st == pmrc_pkg::ST_PDOWN && q.s2.wake_n |=> $stable(q.st))
    else $error("Power-down left without the wake pin.");
  AST_WAKE: assert property (
    q.st == pmrc_pkg::ST_PDOWN && !q.s2.wake_n
    |-> ##[1:2] q.st == pmrc_pkg::ST_RESET && q.pwr.power)
    else $error("Wake pulse did not leave power-down.");
  AST_START_WAKE: assert property (
    q.st == pmrc_pkg::ST_DEEP && |(s_edge & q.sen) && !src_rst
    |=> q.st == pmrc_pkg::ST_RUN ##0 q.pwr.analog)
    else $error("Start pin did not wake deep sleep.");
  AST_START_LINE: assert property (
    |(s_edge & q.sen) && !src_rst |=> |(q.sirq & $past(s_edge)))
    else $error("Start event missing its own line.");
  AST_RST_SRC: assert property (
    src_rst && q.st != pmrc_pkg::ST_PDOWN
    |=> q.sys_rst && q.pwr.internal_rc_osc ##1 q.sys_rst)
    else $error("Reset source did not reset the chip.");
  AST_FLASH: assert property (
    $fell(q.sys_rst) |-> $past(q.finit, RST_HOLD_CYC - 1))
    else $error("Flash initialise not given before release.");
  AST_FETCH: assert property (
    $fell(q.sys_rst) |-> q.fetch == pmrc_pkg::BOOT_FETCH_ADDR
    && q.clk_sel == pmrc_pkg::CLK_IRC)
    else $error("Bad first fetch or clock at release.");
  AST_BOD_IRQ: assert property (
    q.pwr.brownout_detector && q.s2.bod_irq[q.bod_ilvl] && !src_rst |=> q.bod_irq)
    else $error("Brown-out interrupt missing.");
  AST_ISP: assert property (
    $fell(q.sys_rst) |-> q.boot_isp == !$past(q.s2.boot_n))
    else $error("Boot request not captured at release.");

endmodule : power_mode_reset_control

// ==== power_mode_reset_control_bench.sv ====
// Self-checking bench of the power-mode and reset controller.
`timescale 1ns/1ps
module power_mode_reset_control_bench;
  // ****************************************************************
  // Signals and counters.
  // ****************************************************************
  logic                 clk_i = 1'b0;            // 40 MHz clock.
  logic                 rst_i = 1'b1;            // Reset, high.
  logic                 cyc = 1'b0, stb = 1'b0;  // Bus request.
  logic                 we = 1'b0;               // Bus direction.
  logic [4:0]           adr = 5'h00;             // Bus address.
  logic [31:0]          dat = 32'h0, rd, rdat;   // Bus data.
  logic                 ack, slp, irq, srst, bisp, birq; // Outputs.
  logic                 slp_cmd = 1'b0, irq_cmd = 1'b0;   // To core.
  pmrc_pkg::pins_t      pins;                    // Raw pins.
  pmrc_pkg::pwr_t       pwr;                     // Power enables.
  logic [1:0]           csel;                    // Clock select.
  logic [31:0]          fadr;                    // Fetch address.
  logic [39:0]          sirq;                    // Start lines.
  logic                 wdt = 1'b0, finit;       // Watchdog, flash init.
  int                   fi_cnt = 0;              // Flash init pulses.
  int                   err_total = 0, num_checks = 0, cyc_cnt = 0;

  always #12.5 clk_i = ~clk_i;

  power_mode_reset_control #(.RST_HOLD_CYC(8'h02)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pins_i(pins), .wdt_rst_i(wdt),
    .sleep_req_i(slp), .irq_i(irq), .pwr_o(pwr), .clk_sel_o(csel),
    .sys_rst_o(srst), .flash_init_o(finit), .fetch_addr_o(fadr),
    .boot_isp_o(bisp), .bod_irq_o(birq), .start_irq_o(sirq));

  // Flash init pulses are counted mid-cycle, where the pin is settled.
  always @(negedge clk_i) if (finit === 1'b1) fi_cnt++;

  core_model partner (.clk_i(clk_i), .sleep_cmd_i(slp_cmd),
    .irq_cmd_i(irq_cmd), .sleep_req_o(slp), .irq_o(irq));

  // Compares one value, counting every check and every mismatch.
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Classic Wishbone cycle; read data is taken mid-cycle once ack is seen high.
  task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    // Ack is looked at mid-cycle, so the edge that launches it never races.
    @(negedge clk_i);
    while (ack !== 1'b1) @(negedge clk_i);
    rd = rdat;
    @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // Writes the mode word, then lets the core ask for sleep once.
  task sleep_in(input logic [31:0] mode);
    wb(1'b1, pmrc_pkg::REG_MODE, mode);
    slp_cmd <= 1'b1;
    @(posedge clk_i);
    slp_cmd <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : sleep_in

  // Prints the counts and the verdict, then stops the run.
  task print_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // A hang is cut short well past the hundred or so cycles expected.
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      err_total++;
      print_verdict;
    end
  end

  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    pins = '0;
    pins.wake_n = 1'b1;
    pins.rst_n = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    pins.boot_n <= 1'b1;
    chk({31'h0, srst}, 32'h0, "reset out");
    chk({25'h0, pwr}, 32'h7f, "pwr run");
    chk({30'h0, csel}, 32'h0, "clk sel");
    chk(fadr, 32'h0, "fetch");
    chk({31'h0, bisp}, 32'h1, "boot");
    chk(fi_cnt, 32'h1, "flash init");
    wb(1'b0, pmrc_pkg::REG_CAUSE, 32'h0);
    chk(rd, 32'h0, "cause");
    $display("Test reset done");
    sleep_in(32'h0);
    chk({25'h0, pwr}, 32'h3f, "light");
    irq_cmd <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({25'h0, pwr}, 32'h7f, "light wake");
    irq_cmd <= 1'b0;
    sleep_in(32'h3);
    chk({25'h0, pwr}, 32'h7f, "no sleep mode");
    $display("Test light sleep done");
    wb(1'b1, pmrc_pkg::REG_SEN_HI, 32'h80);
    sleep_in(32'h5);
    chk({25'h0, pwr}, 32'h05, "deep");
    pins.start[39] <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk({25'h0, pwr}, 32'h7f, "deep wake");
    chk({24'h0, sirq[39:32]}, 32'h80, "line hi");
    chk(sirq[31:0], 32'h0, "line lo");
    wb(1'b0, pmrc_pkg::REG_SPD_HI, 32'h0);
    chk(rd, 32'h80, "pending");
    $display("Test deep sleep done");
    wb(1'b1, pmrc_pkg::REG_BOD, 32'h2);
    pins.bod_irq <= 4'b0100;
    repeat (6) @(posedge clk_i);
    chk({31'h0, birq}, 32'h1, "bod irq");
    wb(1'b0, pmrc_pkg::REG_STAT, 32'h0);
    chk(rd, 32'h3, "stat");
    pins.bod_irq <= 4'b0010;
    repeat (6) @(posedge clk_i);
    chk({31'h0, birq}, 32'h0, "bod level");
    wb(1'b1, pmrc_pkg::REG_BOD, 32'h16);
    pins.bod_rst <= 4'b0010;
    repeat (4) @(posedge clk_i);
    chk({31'h0, srst}, 32'h1, "forced");
    pins.bod_rst <= 4'h0;
    repeat (8) @(posedge clk_i);
    wb(1'b0, pmrc_pkg::REG_CAUSE, 32'h0);
    chk(rd, 32'h08, "bod cause");
    wdt <= 1'b1;
    @(posedge clk_i);
    wdt <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, srst}, 32'h1, "wdt reset");
    repeat (6) @(posedge clk_i);
    wb(1'b0, pmrc_pkg::REG_CAUSE, 32'h0);
    chk(rd, 32'h0c, "wdt cause");
    wb(1'b1, pmrc_pkg::REG_CAUSE, 32'h1f);
    $display("Test brown-out done");
    sleep_in(32'h2);
    chk({25'h0, pwr}, 32'h0, "pdown");
    irq_cmd <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({25'h0, pwr}, 32'h0, "pdown irq");
    irq_cmd <= 1'b0;
    pins.wake_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    pins.wake_n <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk({25'h0, pwr}, 32'h7f, "wake");
    chk({30'h0, csel}, 32'h0, "wake clk");
    wb(1'b0, pmrc_pkg::REG_CAUSE, 32'h0);
    chk(rd, 32'h10, "wake cause");
    $display("Test power-down done");
    print_verdict;
  end
endmodule : power_mode_reset_control_bench
